// ==== design/qdw_pkg.sv ====
// Package of constants and types for the quad converter serial write port
package qdw_pkg;
	localparam int FRAME_BITS = 16;
	localparam int CODE_BITS = 10;
	localparam int DATA_BITS = 12;
	localparam int CHANNELS = 4;
	localparam int ADDR_HI = 15;
	localparam int ADDR_LO = 14;
	localparam int OP_HI = 13;
	localparam int OP_LO = 12;
	localparam int DATA_HI = 11;
	localparam logic [CODE_BITS-1:0] CODE_RESET = 10'h000;
	localparam int SYNC_STAGES = 2;

	typedef enum logic [1:0] {
		QDW_OP_LOAD = 2'b00,
		QDW_OP_LOAD_UPD = 2'b01,
		QDW_OP_ALL_UPD = 2'b10,
		QDW_OP_PDOWN = 2'b11
	} qdw_op_t;

	typedef enum logic [1:0] {
		QDW_TERM_HIZ = 2'b00,
		QDW_TERM_LOW_R = 2'b01,
		QDW_TERM_HIGH_R = 2'b10
	} qdw_term_t;

	typedef enum logic [1:0] {
		QDW_ST_IDLE = 2'b00,
		QDW_ST_SHIFT = 2'b01,
		QDW_ST_DONE = 2'b10
	} qdw_state_t;
endpackage

// ==== design/qdw_sync.sv ====
// Two-flop synchroniser bank for the serial link pins
module qdw_sync #(
	parameter int WIDTH = 3
) (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	// Asynchronous inputs and their synchronised copies
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_r;
	logic [WIDTH-1:0] meta_nxt;
	logic [WIDTH-1:0] sync_r;
	logic [WIDTH-1:0] sync_nxt;

	if (WIDTH < 1) begin : g_bad_width
		$error("qdw_sync width must be positive");
	end

	always_comb begin
		meta_nxt = async_in;
		sync_nxt = meta_r;
	end

	// Both stages clear to low: a falling-edge detector behind this bank
	// then cannot report an edge straight after reset, whatever the pin.
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			meta_r <= '0;
			sync_r <= '0;
		end else begin
			meta_r <= meta_nxt;
			sync_r <= sync_nxt;
		end
	end

	assign sync_out = sync_r;
endmodule

// ==== design/qdw_write_port.sv ====
// Serial write front end of a quad ten-bit converter
module qdw_write_port
	import qdw_pkg::*;
#(
	parameter int CH = CHANNELS
) (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	// Serial link from the host
	input wire logic frame_sel_n_in,
	input wire logic sclk_in,
	input wire logic sdata_in,
	// Channel codes and state
	output logic [CH*CODE_BITS-1:0] chan_code_out,
	output logic [CH*CODE_BITS-1:0] out_code_out,
	output logic powered_down_out,
	output logic [1:0] term_mode_out,
	output logic cmd_done_out
);
	// ------------------------------------------------------------
	// Pin synchronisation and edge finding
	// ------------------------------------------------------------
	logic [2:0] pins_s;
	logic sel_n_s;
	logic sclk_s;
	logic sdata_s;
	logic sclk_d_r;
	logic sclk_d_nxt;
	logic sel_d_r;
	logic sel_d_nxt;
	logic sclk_fall;
	logic sel_fall;

	// The address field is two bits wide, so exactly four channels are served
	if (CH != CHANNELS) begin : g_bad_ch
		$error("qdw_write_port supports four channels");
	end

	qdw_sync #(.WIDTH(3)) u_sync (
		.clk_in(clk_in),
		.rst_in(rst_in),
		.async_in({frame_sel_n_in, sclk_in, sdata_in}),
		.sync_out(pins_s)
	);

	assign sel_n_s = pins_s[2];
	assign sclk_s = pins_s[1];
	assign sdata_s = pins_s[0];
	// Data is sampled from the same synchronised vector as the clock, so
	// it stays aligned with the edge; host hold time covers the 2 cycles.
	assign sclk_fall = sclk_d_r & ~sclk_s;
	assign sel_fall = sel_d_r & ~sel_n_s;

	// ------------------------------------------------------------
	// Frame state machine and shift register
	// ------------------------------------------------------------
	qdw_state_t state_r;
	qdw_state_t state_nxt;
	logic [FRAME_BITS-1:0] shift_r;
	logic [FRAME_BITS-1:0] shift_nxt;
	logic [4:0] count_r;
	logic [4:0] count_nxt;
	logic exec;
	logic [FRAME_BITS-1:0] word;

	always_comb begin
		state_nxt = state_r;
		shift_nxt = shift_r;
		count_nxt = count_r;
		exec = 1'b0;
		sclk_d_nxt = sclk_s;
		sel_d_nxt = sel_n_s;
		word = {shift_r[FRAME_BITS-2:0], sdata_s};
		case (state_r)
			QDW_ST_IDLE: begin
				if (sel_fall) begin
					state_nxt = QDW_ST_SHIFT;
					count_nxt = 5'h00;
				end
			end
			QDW_ST_SHIFT: begin
				if (sel_n_s) begin
					state_nxt = QDW_ST_IDLE;
				end else if (sclk_fall) begin
					shift_nxt = word;
					count_nxt = count_r + 5'h01;
					if (count_r == 5'(FRAME_BITS - 1)) begin
						exec = 1'b1;
						state_nxt = QDW_ST_DONE;
					end
				end
			end
			QDW_ST_DONE: begin
				if (sel_n_s) state_nxt = QDW_ST_IDLE;
			end
			default: state_nxt = QDW_ST_IDLE;
		endcase
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			state_r <= QDW_ST_IDLE;
			shift_r <= 16'h0000;
			count_r <= 5'h00;
			// Low like the synchroniser: a select held low through reset
			// shows no fall, so it never opens a frame
			sclk_d_r <= 1'b0;
			sel_d_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			shift_r <= shift_nxt;
			count_r <= count_nxt;
			sclk_d_r <= sclk_d_nxt;
			sel_d_r <= sel_d_nxt;
		end
	end

	// ------------------------------------------------------------
	// Command decode and channel registers
	// ------------------------------------------------------------
	logic [CODE_BITS-1:0] code_r [CH];
	logic [CODE_BITS-1:0] code_nxt [CH];
	logic [CODE_BITS-1:0] outc_r [CH];
	logic [CODE_BITS-1:0] outc_nxt [CH];
	logic pd_r;
	logic pd_nxt;
	logic [1:0] term_r;
	logic [1:0] term_nxt;
	logic done_r;
	logic done_nxt;
	logic [1:0] addr;
	qdw_op_t op;
	logic [CODE_BITS-1:0] val;

	always_comb begin
		addr = word[ADDR_HI:ADDR_LO];
		op = qdw_op_t'(word[OP_HI:OP_LO]);
		val = word[DATA_HI -: CODE_BITS];
		pd_nxt = pd_r;
		term_nxt = term_r;
		done_nxt = exec;
		for (int i = 0; i < CH; i++) begin
			code_nxt[i] = code_r[i];
			outc_nxt[i] = outc_r[i];
		end
		if (exec) begin
			case (op)
				QDW_OP_PDOWN: begin
					pd_nxt = 1'b1;
					term_nxt = (addr == 2'b11) ? QDW_TERM_HIZ : addr;
				end
				QDW_OP_LOAD: begin
					code_nxt[addr] = val;
					pd_nxt = 1'b0;
				end
				QDW_OP_LOAD_UPD, QDW_OP_ALL_UPD: begin
					pd_nxt = 1'b0;
					for (int i = 0; i < CH; i++) begin
						if (op == QDW_OP_ALL_UPD || addr == 2'(i)) begin
							code_nxt[i] = val;
						end
						outc_nxt[i] = code_nxt[i];
					end
				end
				default: pd_nxt = pd_r;
			endcase
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			for (int i = 0; i < CH; i++) begin
				code_r[i] <= CODE_RESET;
				outc_r[i] <= CODE_RESET;
			end
			pd_r <= 1'b0;
			term_r <= QDW_TERM_HIZ;
			done_r <= 1'b0;
		end else begin
			for (int i = 0; i < CH; i++) begin
				code_r[i] <= code_nxt[i];
				outc_r[i] <= outc_nxt[i];
			end
			pd_r <= pd_nxt;
			term_r <= term_nxt;
			done_r <= done_nxt;
		end
	end

	always_comb begin
		for (int i = 0; i < CH; i++) begin
			chan_code_out[i*CODE_BITS +: CODE_BITS] = code_r[i];
			out_code_out[i*CODE_BITS +: CODE_BITS] = outc_r[i];
		end
	end
	assign powered_down_out = pd_r;
	assign term_mode_out = term_r;
	assign cmd_done_out = done_r;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	a_exec_on_sixteen: assert property (@(posedge clk_in)
		disable iff (rst_in)
		exec |-> (state_r == QDW_ST_SHIFT && count_r == 5'd15 && sclk_fall))
		else $error("command executed off the sixteenth edge");
	a_done_follows: assert property (@(posedge clk_in)
		disable iff (rst_in)
		exec |=> cmd_done_out && state_r == QDW_ST_DONE)
		else $error("done pulse missing after command");
	a_abort_no_change: assert property (@(posedge clk_in)
		disable iff (rst_in)
		(state_r == QDW_ST_SHIFT && sel_n_s) |=> $stable(chan_code_out)
		&& $stable(out_code_out) && $stable(term_mode_out)
		&& $stable(powered_down_out) && state_r == QDW_ST_IDLE)
		else $error("aborted frame changed state");
	// The last shift lands on the edge that enters DONE, so stability is
	// judged from the following cycle on
	a_done_ignores: assert property (@(posedge clk_in)
		disable iff (rst_in)
		(state_r == QDW_ST_DONE) |-> !exec ##1 $stable(shift_r))
		else $error("clock used after sixteenth edge");
	a_idle_ignores: assert property (@(posedge clk_in)
		disable iff (rst_in)
		(state_r == QDW_ST_IDLE) |=> $stable(shift_r) && $stable(out_code_out))
		else $error("link used while deselected");
	a_shift_bit: assert property (@(posedge clk_in)
		disable iff (rst_in)
		(state_r == QDW_ST_SHIFT && !sel_n_s && sclk_fall)
		|=> shift_r[0] == $past(sdata_s) && count_r == $past(count_r) + 5'd1)
		else $error("bit not shifted on falling edge");
	a_pd_keeps: assert property (@(posedge clk_in)
		disable iff (rst_in)
		(exec && op == QDW_OP_PDOWN) |=> $stable(chan_code_out)
		&& powered_down_out)
		else $error("power-down altered a channel code");
	a_wake_up: assert property (@(posedge clk_in)
		disable iff (rst_in)
		(exec && op != QDW_OP_PDOWN) |=> !powered_down_out)
		else $error("valid command left device powered down");
	a_term_map: assert property (@(posedge clk_in)
		disable iff (rst_in)
		(exec && op == QDW_OP_PDOWN && addr == 2'b11) |=> term_mode_out == 2'b00)
		else $error("address 11 not mapped to high impedance");
	a_new_frame: assert property (@(posedge clk_in)
		disable iff (rst_in)
		(state_r == QDW_ST_IDLE && !sel_fall) |=> state_r == QDW_ST_IDLE)
		else $error("frame began without select falling");
endmodule

// ==== verification/qdw_host.sv ====
// Host-side serial controller model driving the converter write port
module qdw_host (
	// Clock
	input wire logic clk_in,
	// Serial link towards the device
	output logic frame_sel_n_out,
	output logic sclk_out,
	output logic sdata_out
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		frame_sel_n_out = 1'b1;
		sclk_out = 1'b0;
		sdata_out = 1'b0;
	end
	task automatic wait_clk(input int n);
		repeat (n) @(posedge clk_in);
	endtask
	// Clock stands low outside frames, so select never falls with it
	// Pulses past the sixteenth carry toggling junk to expose overrun
	task automatic send(input logic [15:0] word, input int pulses);
		int i;
		@(posedge clk_in);
		frame_sel_n_out <= 1'b0;
		wait_clk(4);
		for (i = 0; i < pulses; i++) begin
			sclk_out <= 1'b1;
			sdata_out <= (i < 16) ? word[15-i] : ~sdata_out;
			wait_clk(4);
			sclk_out <= 1'b0;
			wait_clk(4);
		end
		frame_sel_n_out <= 1'b1;
		sdata_out <= 1'b0;
		wait_clk(4);
	endtask
endmodule

// ==== verification/tb_top.sv ====
// Self-checking testbench for the converter serial write port
module tb_top
	import qdw_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_in = 1'b0;
	logic rst_in = 1'b1;
	logic sel_n, sclk, sdata, pd, exp_pd, done;
	logic [4*CODE_BITS-1:0] chan_code, out_code, exp_chan, exp_out;
	logic [1:0] term, exp_term;
	int n_mismatch = 0;
	int cmp_count = 0;
	int done_cnt = 0;
	always #12.5 clk_in = ~clk_in;
	always @(posedge clk_in) if (done === 1'b1) done_cnt++;
	qdw_host qdw_host_i (.clk_in(clk_in), .frame_sel_n_out(sel_n),
		.sclk_out(sclk), .sdata_out(sdata));
	qdw_write_port qdw_write_port_i (.clk_in(clk_in), .rst_in(rst_in),
		.frame_sel_n_in(sel_n), .sclk_in(sclk), .sdata_in(sdata),
		.chan_code_out(chan_code), .out_code_out(out_code),
		.powered_down_out(pd), .term_mode_out(term), .cmd_done_out(done));
	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic check(input logic ok);
		cmp_count++;
		if (ok !== 1'b1) begin
			n_mismatch++;
			$display("Error at %0t: outputs differ from expected", $time);
		end
	endtask
	// Sends one frame, updates the expectation, then compares
	task automatic frame(input logic [1:0] a, input qdw_op_t op,
		input logic [11:0] d, input int n);
		int c0;
		int k;
		c0 = done_cnt;
		qdw_host_i.send({a, op, d}, n);
		if (n >= 16) begin
			case (op)
				QDW_OP_ALL_UPD: begin
					for (k = 0; k < 4; k++) begin
						exp_chan[k*CODE_BITS +: CODE_BITS] = d[11:2];
					end
				end
				QDW_OP_PDOWN: begin
					exp_pd = 1'b1;
					exp_term = (a == 2'b11) ? 2'b00 : a;
				end
				default: begin
					exp_chan[a*CODE_BITS +: CODE_BITS] = d[11:2];
				end
			endcase
			if (op == QDW_OP_LOAD_UPD || op == QDW_OP_ALL_UPD) exp_out = exp_chan;
			if (op != QDW_OP_PDOWN) exp_pd = 1'b0;
		end
		check(chan_code === exp_chan && out_code === exp_out);
		check(pd === exp_pd && (!exp_pd || term === exp_term));
		check(done_cnt == c0 + ((n >= 16) ? 1 : 0));
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset();
		check(chan_code === '0 && out_code === '0 && pd === 1'b0);
	endtask
	task automatic t_load();
		frame(2'b01, QDW_OP_LOAD, 12'habc, 16);
		frame(2'b10, QDW_OP_LOAD, 12'h3ff, 16);
	endtask
	task automatic t_update();
		frame(2'b11, QDW_OP_LOAD_UPD, 12'hfff, 16);
	endtask
	task automatic t_abort();
		frame(2'b00, QDW_OP_ALL_UPD, 12'h555, 10);
		frame(2'b00, QDW_OP_PDOWN, 12'h000, 15);
	endtask
	task automatic t_extra();
		frame(2'b00, QDW_OP_LOAD_UPD, 12'h800, 20);
		frame(2'b01, QDW_OP_LOAD, 12'h001, 16);
	endtask
	task automatic t_all();
		frame(2'b10, QDW_OP_ALL_UPD, 12'h004, 16);
	endtask
	task automatic t_pdown();
		int a;
		for (a = 0; a < 4; a++) begin
			frame(a[1:0], QDW_OP_PDOWN, 12'hfff, 16);
		end
		frame(2'b10, QDW_OP_LOAD, 12'h7fc, 16);
	endtask
	task automatic close_out();
		$display("Comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	initial begin
		exp_chan = '0;
		exp_out = '0;
		exp_pd = 1'b0;
		exp_term = 2'b00;
		repeat (8) @(posedge clk_in);
		rst_in <= 1'b0;
		repeat (3) @(posedge clk_in);
		t_reset();
		t_all();
		t_load();
		t_update();
		t_abort();
		t_extra();
		t_pdown();
		close_out();
	end
	// Whole run needs about 1800 cycles; this leaves ample margin
	initial begin
		repeat (20000) @(posedge clk_in);
		n_mismatch++;
		close_out();
	end
endmodule
